// [core/dpspd_map.svh]
`ifndef DPSPD_MAP_SVH
`define DPSPD_MAP_SVH

// ----------------------------------------------------------------------
// Bus widths and register offsets
// ----------------------------------------------------------------------
`define DPSPD_ADDR_W 4
`define DPSPD_DATA_W 8
`define DPSPD_REG_REF_DIV 4'h0
`define DPSPD_REG_OSC_DIV 4'h1
`define DPSPD_REG_PUMP_CTRL 4'h2
`define DPSPD_REG_TAP_CTRL 4'h3
`define DPSPD_REG_STATUS 4'h4

// ----------------------------------------------------------------------
// Field layout and widths
// ----------------------------------------------------------------------
`define DPSPD_DIV_W 7
`define DPSPD_GAIN_W 4
`define DPSPD_GAIN_LSB 0
`define DPSPD_INVERT_BIT 4
`define DPSPD_TAP_REF_BIT 0
`define DPSPD_TAP_OSC_BIT 1

// ----------------------------------------------------------------------
// Reset values and channel numbering
// ----------------------------------------------------------------------
`define DPSPD_DIV_RST 7'h00
`define DPSPD_GAIN_RST 4'h0
`define DPSPD_TAP_RST 2'h0
`define DPSPD_CNT_RST 7'h7F
`define DPSPD_NUM_CH 2
`define DPSPD_CH_REF 0
`define DPSPD_CH_OSC 1

`endif

// [core/dpspd_pkg.sv]
package dpspd_pkg;

   // Phase comparator states.
   typedef enum logic [1:0] {
      DPSPD_IDLE  = 2'b00,
      DPSPD_RAISE = 2'b01,
      DPSPD_LOWER = 2'b10
   } dpspd_cmp_t;

   typedef logic [6:0] dpspd_ratio_t;

endpackage

// [core/dpspd_divider.sv]
`timescale 1ns/100ps
`include "dpspd_map.svh"

module dpspd_divider
   import dpspd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic in_level,
   input wire dpspd_ratio_t ratio,
   output logic div_level,
   output logic div_edge
);

   logic in_prev_r;
   logic rise;
   logic fall;
   logic wrap;
   dpspd_ratio_t eff;
   dpspd_ratio_t half;
   dpspd_ratio_t cnt_r;
   dpspd_ratio_t cnt_nxt;

   assign rise = in_level & ~in_prev_r;
   assign fall = ~in_level & in_prev_r;
   // A zero word divides by one.
   assign eff = (ratio == 7'h00) ? 7'h01 : ratio;
   assign half = 7'((8'(eff) + 8'h01) >> 1);
   // Greater-or-equal lets a shrinking ratio wrap at once instead of
   // running the counter round all 128 codes.
   assign wrap = (cnt_r >= 7'(eff - 7'h01));
   assign cnt_nxt = wrap ? 7'h00 : 7'(cnt_r + 7'h01);

   always_ff @(posedge clk) begin
      if (srst) begin
         in_prev_r <= 1'b0;
      end else begin
         in_prev_r <= in_level;
      end
   end

   // Starting at the top code makes the first input edge close a cycle,
   // so the level and the divided edge agree from the first period on.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= `DPSPD_CNT_RST;
      end else if (rise) begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div_edge <= 1'b0;
      end else begin
         div_edge <= rise & wrap;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div_level <= 1'b0;
      end else if (eff == 7'h01) begin
         if (rise) begin
            div_level <= 1'b1;
         end else if (fall) begin
            div_level <= 1'b0;
         end
      end else if (rise) begin
         div_level <= (cnt_nxt < half);
      end
   end

endmodule

// [core/dpspd_top.sv]
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "dpspd_map.svh"

// Behaviour
// - Two independent dividers each divide by a 7-bit word from 1 to 127.
// - A reference word of all zeros divides the reference by one.
// - The oscillator divider uses its own word with the same coding.
// - A word is an unsigned binary ratio with bit 6 as its top bit.
// - A new word is taken at once so a sequencer can change it freely.
// - The comparator drives separate raise and lower pulse outputs.
// - A 4-bit gain word scales the pulse level, all ones being maximum.
// - Pump level rises one step per gain count, zero giving no pulse.
// - An invert control of one swaps the raise and lower outputs.
// - Unset divide, gain and invert controls are taken as zero.
// - The divided reference and oscillator appear on two taps.
// - Each tap can be switched off alone without touching the comparator.
module dpspd_top
   import dpspd_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic REF_IN_POS,
   input wire logic REF_IN_NEG,
   input wire logic OSC_IN_POS,
   input wire logic OSC_IN_NEG,
   input wire logic [`DPSPD_ADDR_W-1:0] BUS_ADDR,
   input wire logic [`DPSPD_DATA_W-1:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [`DPSPD_DATA_W-1:0] BUS_RDATA,
   output logic RAISE_PULSE_POS,
   output logic RAISE_PULSE_NEG,
   output logic LOWER_PULSE_POS,
   output logic LOWER_PULSE_NEG,
   output logic [`DPSPD_GAIN_W-1:0] PUMP_GAIN,
   output logic DIVIDED_REF_TAP,
   output logic DIVIDED_OSC_TAP
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic [`DPSPD_NUM_CH-1:0] chan_level_r;
   logic [`DPSPD_NUM_CH-1:0] div_level;
   logic [`DPSPD_NUM_CH-1:0] div_edge;
   dpspd_ratio_t ratio_r [`DPSPD_NUM_CH];
   logic [`DPSPD_GAIN_W-1:0] gain_r;
   logic invert_r;
   logic [1:0] tap_en_r;
   dpspd_cmp_t cmp_r;
   dpspd_cmp_t cmp_nxt;
   logic raise_act;
   logic lower_act;
   logic pump_on;
   logic [`DPSPD_DATA_W-1:0] rdata_nxt;
   logic ref_edge;
   logic osc_edge;

   assign ref_edge = div_edge[`DPSPD_CH_REF];
   assign osc_edge = div_edge[`DPSPD_CH_OSC];

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // The RF pins arrive from outside the clock domain, so each leg is
   // caught by two flops before any decode looks at it. This limits the
   // usable input rate to well below half the clock.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         pin_meta_r <= 4'h0;
      end else begin
         pin_meta_r <= {OSC_IN_NEG, OSC_IN_POS, REF_IN_NEG, REF_IN_POS};
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         pin_sync_r <= 4'h0;
      end else begin
         pin_sync_r <= pin_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Per-channel decode and divider
   // ---------------------------------------------------------------
   // A differential pair changes level only when its legs disagree; a
   // pair with both legs equal holds the last level, which rejects a
   // single-ended input whose other leg is simply terminated.
   genvar ch;
   generate
      for (ch = 0; ch < `DPSPD_NUM_CH; ch = ch + 1) begin : g_chan
         always_ff @(posedge CLOCK) begin
            if (SRST) begin
               chan_level_r[ch] <= 1'b0;
            end else if (pin_sync_r[2*ch] != pin_sync_r[2*ch+1]) begin
               chan_level_r[ch] <= pin_sync_r[2*ch];
            end
         end

         dpspd_divider u_div (
            .clk(CLOCK),
            .srst(SRST),
            .in_level(chan_level_r[ch]),
            .ratio(ratio_r[ch]),
            .div_level(div_level[ch]),
            .div_edge(div_edge[ch])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Reset to zero stands for a control left unset.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ratio_r[`DPSPD_CH_REF] <= `DPSPD_DIV_RST;
      end else if (BUS_WR && BUS_ADDR == `DPSPD_REG_REF_DIV) begin
         ratio_r[`DPSPD_CH_REF] <= BUS_WDATA[`DPSPD_DIV_W-1:0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ratio_r[`DPSPD_CH_OSC] <= `DPSPD_DIV_RST;
      end else if (BUS_WR && BUS_ADDR == `DPSPD_REG_OSC_DIV) begin
         ratio_r[`DPSPD_CH_OSC] <= BUS_WDATA[`DPSPD_DIV_W-1:0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         gain_r <= `DPSPD_GAIN_RST;
         invert_r <= 1'b0;
      end else if (BUS_WR && BUS_ADDR == `DPSPD_REG_PUMP_CTRL) begin
         gain_r <= BUS_WDATA[`DPSPD_GAIN_LSB+:`DPSPD_GAIN_W];
         invert_r <= BUS_WDATA[`DPSPD_INVERT_BIT];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         tap_en_r <= `DPSPD_TAP_RST;
      end else if (BUS_WR && BUS_ADDR == `DPSPD_REG_TAP_CTRL) begin
         tap_en_r <= {BUS_WDATA[`DPSPD_TAP_OSC_BIT],
                      BUS_WDATA[`DPSPD_TAP_REF_BIT]};
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (BUS_RD) begin
         unique case (BUS_ADDR)
            `DPSPD_REG_REF_DIV: begin
               rdata_nxt = {1'b0, ratio_r[`DPSPD_CH_REF]};
            end
            `DPSPD_REG_OSC_DIV: begin
               rdata_nxt = {1'b0, ratio_r[`DPSPD_CH_OSC]};
            end
            `DPSPD_REG_PUMP_CTRL: begin
               rdata_nxt = {3'h0, invert_r, gain_r};
            end
            `DPSPD_REG_TAP_CTRL: begin
               rdata_nxt = {6'h00, tap_en_r};
            end
            `DPSPD_REG_STATUS: begin
               rdata_nxt = {4'h0, div_level[`DPSPD_CH_OSC],
                            div_level[`DPSPD_CH_REF],
                            cmp_r == DPSPD_LOWER, cmp_r == DPSPD_RAISE};
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // Read data stand for the one cycle after the strobe only.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         BUS_RDATA <= 8'h00;
      end else begin
         BUS_RDATA <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Phase-frequency comparator
   // ---------------------------------------------------------------
   // Edges that land in the same cycle cancel, so there is no separate
   // both-set state: the pair is cleared in the very cycle it forms.
   always_comb begin
      cmp_nxt = cmp_r;
      unique case (cmp_r)
         DPSPD_IDLE: begin
            if (ref_edge && !osc_edge) begin
               cmp_nxt = DPSPD_RAISE;
            end else if (osc_edge && !ref_edge) begin
               cmp_nxt = DPSPD_LOWER;
            end
         end
         DPSPD_RAISE: begin
            if (osc_edge) begin
               cmp_nxt = DPSPD_IDLE;
            end
         end
         DPSPD_LOWER: begin
            if (ref_edge) begin
               cmp_nxt = DPSPD_IDLE;
            end
         end
         default: begin
            cmp_nxt = DPSPD_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         cmp_r <= DPSPD_IDLE;
      end else begin
         cmp_r <= cmp_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pump outputs
   // ---------------------------------------------------------------
   // Gain zero means zero current, so both legs of each pair rest low.
   assign pump_on = (gain_r != 4'h0);
   assign raise_act = invert_r ? (cmp_r == DPSPD_LOWER)
                               : (cmp_r == DPSPD_RAISE);
   assign lower_act = invert_r ? (cmp_r == DPSPD_RAISE)
                               : (cmp_r == DPSPD_LOWER);

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         RAISE_PULSE_POS <= 1'b0;
         RAISE_PULSE_NEG <= 1'b0;
         LOWER_PULSE_POS <= 1'b0;
         LOWER_PULSE_NEG <= 1'b0;
      end else begin
         RAISE_PULSE_POS <= pump_on & raise_act;
         RAISE_PULSE_NEG <= pump_on & ~raise_act;
         LOWER_PULSE_POS <= pump_on & lower_act;
         LOWER_PULSE_NEG <= pump_on & ~lower_act;
      end
   end

   // The analog stage turns this code into current, one step per count.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         PUMP_GAIN <= 4'h0;
      end else begin
         PUMP_GAIN <= gain_r;
      end
   end

   // ---------------------------------------------------------------
   // Monitor taps
   // ---------------------------------------------------------------
   // Gating sits after the divider so a dark tap never upsets the
   // comparator path.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         DIVIDED_REF_TAP <= 1'b0;
         DIVIDED_OSC_TAP <= 1'b0;
      end else begin
         DIVIDED_REF_TAP <= tap_en_r[0] & div_level[`DPSPD_CH_REF];
         DIVIDED_OSC_TAP <= tap_en_r[1] & div_level[`DPSPD_CH_OSC];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_unity_ref_pass: assert property (
      @(posedge CLOCK) disable iff (SRST)
      ($rose(chan_level_r[0]) && ratio_r[0] == 7'h00) |=> div_edge[0])
      else $error("Reference edge lost at divide by one.");

   a_unity_osc_pass: assert property (
      @(posedge CLOCK) disable iff (SRST)
      ($rose(chan_level_r[1]) && ratio_r[1] == 7'h00) |=> div_edge[1])
      else $error("Oscillator edge lost at divide by one.");

   a_ref_sets_raise: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (cmp_r == DPSPD_IDLE && ref_edge && !osc_edge)
      |=> cmp_r == DPSPD_RAISE)
      else $error("Reference edge did not set raise.");

   a_osc_sets_lower: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (cmp_r == DPSPD_IDLE && osc_edge && !ref_edge)
      |=> cmp_r == DPSPD_LOWER)
      else $error("Oscillator edge did not set lower.");

   a_both_clear: assert property (
      @(posedge CLOCK) disable iff (SRST)
      ((cmp_r == DPSPD_RAISE && osc_edge) ||
       (cmp_r == DPSPD_LOWER && ref_edge)) |=> cmp_r == DPSPD_IDLE)
      else $error("Pulses did not clear together.");

   a_raise_normal: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (cmp_r == DPSPD_RAISE && gain_r != 4'h0 && !invert_r)
      |=> RAISE_PULSE_POS && !LOWER_PULSE_POS && LOWER_PULSE_NEG)
      else $error("Raise pulse missing in normal sense.");

   a_sense_swap: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (cmp_r == DPSPD_RAISE && gain_r != 4'h0 && invert_r)
      |=> LOWER_PULSE_POS && !RAISE_PULSE_POS)
      else $error("Inverted sense did not swap pulses.");

   a_zero_gain_quiet: assert property (
      @(posedge CLOCK) disable iff (SRST)
      (gain_r == 4'h0) |=> !RAISE_PULSE_POS && !LOWER_PULSE_POS
                           && !RAISE_PULSE_NEG && !LOWER_PULSE_NEG)
      else $error("Pump driven with zero gain.");

   a_gain_follow: assert property (
      @(posedge CLOCK) disable iff (SRST)
      ##1 PUMP_GAIN == $past(gain_r))
      else $error("Gain code not passed to pump.");

   a_ref_tap_off: assert property (
      @(posedge CLOCK) disable iff (SRST)
      !tap_en_r[0] [*2] |-> !DIVIDED_REF_TAP)
      else $error("Disabled reference tap is active.");

   a_ref_tap_on: assert property (
      @(posedge CLOCK) disable iff (SRST)
      tap_en_r[0] |=> DIVIDED_REF_TAP == $past(div_level[0]))
      else $error("Reference tap does not follow divider.");

   a_reset_zero: assert property (
      @(posedge CLOCK) disable iff (SRST)
      $fell(SRST) |-> ratio_r[0] == 7'h00 && ratio_r[1] == 7'h00
                      && gain_r == 4'h0 && !invert_r)
      else $error("Controls not zero after reset.");

endmodule

// [verif/dpspd_rf_src.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Reference and oscillator sources
// ----------------------------------------------------------------------
// The negative legs are always the complement of the positive legs, so
// the receiver never sees two equal legs and never holds a stale level.
module dpspd_rf_src (
   input wire logic clk,
   output logic ref_pos,
   output logic ref_neg,
   output logic osc_pos,
   output logic osc_neg
);

   assign ref_neg = ~ref_pos;
   assign osc_neg = ~osc_pos;

   initial begin
      ref_pos = 1'b0;
      osc_pos = 1'b0;
   end

   // Sets one source level at the next clock edge.
   task automatic set_lvl(input logic osc, input logic lvl);
      @(posedge clk);
      if (osc) begin
         osc_pos <= lvl;
      end else begin
         ref_pos <= lvl;
      end
   endtask

   task automatic set_all(input logic lvl);
      @(posedge clk);
      ref_pos <= lvl;
      osc_pos <= lvl;
   endtask

   // Runs both sources together; a larger half period gives a slower
   // source, which must never be below two clock cycles per level.
   task automatic burst(input int periods, input int half);
      for (int i = 0; i < periods; i++) begin
         @(posedge clk);
         ref_pos <= 1'b1;
         osc_pos <= 1'b1;
         repeat (half) @(posedge clk);
         ref_pos <= 1'b0;
         osc_pos <= 1'b0;
         repeat (half - 1) @(posedge clk);
      end
   endtask

endmodule

// [verif/dpspd_top_tb.sv]
`timescale 1ns/100ps
`include "dpspd_map.svh"

module dpspd_top_tb
   import dpspd_pkg::*;
;

   // -------------------------------------------------------------------
   // Clock, reset and design hookup
   // -------------------------------------------------------------------
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [3:0] bus_addr = 4'h0;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic raise_pos, raise_neg, lower_pos, lower_neg;
   logic [3:0] pump_gain;
   logic ref_tap, osc_tap;
   logic ref_p, ref_n, osc_p, osc_n;
   int bad_count = 0;
   int tests_run = 0;

   always #10 clock = ~clock;

   dpspd_rf_src SRC (.clk(clock), .ref_pos(ref_p), .ref_neg(ref_n),
      .osc_pos(osc_p), .osc_neg(osc_n));

   dpspd_top DUT (.CLOCK(clock), .SRST(srst), .REF_IN_POS(ref_p),
      .REF_IN_NEG(ref_n), .OSC_IN_POS(osc_p), .OSC_IN_NEG(osc_n),
      .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
      .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata),
      .RAISE_PULSE_POS(raise_pos), .RAISE_PULSE_NEG(raise_neg),
      .LOWER_PULSE_POS(lower_pos), .LOWER_PULSE_NEG(lower_neg),
      .PUMP_GAIN(pump_gain), .DIVIDED_REF_TAP(ref_tap),
      .DIVIDED_OSC_TAP(osc_tap));

   // -------------------------------------------------------------------
   // Output counters
   // -------------------------------------------------------------------
   logic cnt_en = 1'b0;
   logic ref_tap_d, osc_tap_d;
   int n_rr, n_or, n_up, n_dn, n_upn, n_dnn, n_win, n_tap;

   always @(posedge clock) begin
      ref_tap_d <= ref_tap;
      osc_tap_d <= osc_tap;
      if (cnt_en) begin
         n_win++;
         if (ref_tap === 1'b1 && ref_tap_d === 1'b0) n_rr++;
         if (osc_tap === 1'b1 && osc_tap_d === 1'b0) n_or++;
         if (raise_pos === 1'b1) n_up++;
         if (lower_pos === 1'b1) n_dn++;
         if (raise_neg === 1'b1) n_upn++;
         if (lower_neg === 1'b1) n_dnn++;
         if (ref_tap !== 1'b0 || osc_tap !== 1'b0) n_tap++;
      end
   end

   task automatic clr_cnt;
      {n_rr, n_or, n_up, n_dn, n_upn, n_dnn, n_win, n_tap} = '0;
   endtask

   // -------------------------------------------------------------------
   // Compare and bus tasks
   // -------------------------------------------------------------------
   task automatic chk_val(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_cnt(input string nm, input int e, input int g);
      tests_run++;
      if (g != e) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   task automatic do_reset(input int n);
      @(posedge clock);
      srst <= 1'b1;
      repeat (n) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
   endtask

   function automatic int eff(input dpspd_ratio_t r);
      return (r == 7'h00) ? 1 : int'(r);
   endfunction

   task automatic end_of_test;
      $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      end_of_test;
   end

   // -------------------------------------------------------------------
   // Test tables
   // -------------------------------------------------------------------
   typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} dpspd_reg_t;
   dpspd_reg_t reg_rows [6] = '{
      '{`DPSPD_REG_REF_DIV, 8'h7F, 8'h7F},
      '{`DPSPD_REG_OSC_DIV, 8'h40, 8'h40},
      '{`DPSPD_REG_PUMP_CTRL, 8'h1F, 8'h1F},
      '{`DPSPD_REG_TAP_CTRL, 8'h03, 8'h03},
      '{`DPSPD_REG_STATUS, 8'hFF, 8'h00},
      '{4'hF, 8'hA5, 8'h00}};

   typedef struct {dpspd_ratio_t rr; dpspd_ratio_t orr; int p;} dpspd_div_t;
   dpspd_div_t div_rows [5] = '{'{7'h00, 7'h01, 4}, '{7'h02, 7'h03, 6},
      '{7'h04, 7'h05, 20}, '{7'h40, 7'h40, 128}, '{7'h7F, 7'h7F, 127}};

   typedef struct {logic inv; logic [3:0] g; logic osc; int up; int dn;}
      dpspd_cmp_row_t;
   dpspd_cmp_row_t cmp_rows [6] = '{'{1'b0, 4'hF, 1'b0, 5, 0},
      '{1'b0, 4'hF, 1'b1, 0, 5}, '{1'b1, 4'hF, 1'b0, 0, 5},
      '{1'b1, 4'hF, 1'b1, 5, 0}, '{1'b0, 4'h0, 1'b0, 0, 0},
      '{1'b0, 4'h1, 1'b1, 0, 5}};

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      logic [7:0] rd;
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      foreach (reg_rows[i]) bus_write(reg_rows[i].a, reg_rows[i].w);
      foreach (reg_rows[i]) begin
         bus_read(reg_rows[i].a, rd);
         chk_val("register readback", reg_rows[i].r, rd);
      end
      chk_val("pump gain", 4'hF, pump_gain);
      $display("Test register map done");

      foreach (div_rows[i]) begin
         do_reset(4);
         bus_write(`DPSPD_REG_TAP_CTRL, 8'h03);
         bus_write(`DPSPD_REG_REF_DIV, {1'b0, div_rows[i].rr});
         bus_write(`DPSPD_REG_OSC_DIV, {1'b0, div_rows[i].orr});
         clr_cnt();
         cnt_en <= 1'b1;
         SRC.burst(div_rows[i].p, 2);
         repeat (12) @(posedge clock);
         cnt_en <= 1'b0;
         chk_cnt("ref tap edges", div_rows[i].p / eff(div_rows[i].rr),
            n_rr);
         chk_cnt("osc tap edges", div_rows[i].p / eff(div_rows[i].orr),
            n_or);
      end
      $display("Test divide ratios done");

      // A shorter word taken mid-cycle ends the running cycle at the
      // next input edge instead of letting the counter run round.
      do_reset(4);
      bus_write(`DPSPD_REG_TAP_CTRL, 8'h01);
      bus_write(`DPSPD_REG_REF_DIV, 8'h08);
      clr_cnt();
      cnt_en <= 1'b1;
      SRC.burst(3, 2);
      bus_write(`DPSPD_REG_REF_DIV, 8'h02);
      SRC.burst(5, 2);
      repeat (12) @(posedge clock);
      cnt_en <= 1'b0;
      chk_cnt("ref edges after ratio change", 3, n_rr);
      $display("Test ratio change done");

      // Taps stay disabled here while the comparator keeps working.
      do_reset(4);
      foreach (cmp_rows[i]) begin
         bus_write(`DPSPD_REG_PUMP_CTRL, {3'h0, cmp_rows[i].inv,
            cmp_rows[i].g});
         // One edge lets the new gain reach the pump legs before counting.
         @(posedge clock);
         clr_cnt();
         cnt_en <= 1'b1;
         SRC.set_lvl(cmp_rows[i].osc, 1'b1);
         repeat (4) @(posedge clock);
         SRC.set_lvl(~cmp_rows[i].osc, 1'b1);
         repeat (10) @(posedge clock);
         SRC.set_all(1'b0);
         repeat (15) @(posedge clock);
         cnt_en <= 1'b0;
         @(posedge clock);
         chk_val("pump gain", cmp_rows[i].g, pump_gain);
         chk_cnt("raise cycles", cmp_rows[i].up, n_up);
         chk_cnt("lower cycles", cmp_rows[i].dn, n_dn);
         chk_cnt("raise neg cycles", (cmp_rows[i].g != 4'h0) ?
            n_win - cmp_rows[i].up : 0, n_upn);
         chk_cnt("lower neg cycles", (cmp_rows[i].g != 4'h0) ?
            n_win - cmp_rows[i].dn : 0, n_dnn);
         chk_cnt("disabled tap activity", 0, n_tap);
      end
      $display("Test comparator done");

      // Reset lands while a raise pulse is standing.
      bus_write(`DPSPD_REG_PUMP_CTRL, 8'h0F);
      SRC.set_lvl(1'b0, 1'b1);
      repeat (8) @(posedge clock);
      #1;
      chk_val("raise standing", 16'h0001, {15'h0, raise_pos});
      bus_read(`DPSPD_REG_STATUS, rd);
      chk_val("status while raising", 8'h05, rd);
      @(posedge clock);
      srst <= 1'b1;
      SRC.set_lvl(1'b0, 1'b0);
      repeat (3) @(posedge clock);
      #1;
      chk_val("outputs in reset", 16'h0000, {raise_pos, raise_neg,
         lower_pos, lower_neg, pump_gain, ref_tap, osc_tap});
      @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1;
      chk_val("outputs after reset", 16'h0000, {raise_pos, raise_neg,
         lower_pos, lower_neg, pump_gain, ref_tap, osc_tap});
      for (int a = 0; a < 4; a++) begin
         bus_read(a[3:0], rd);
         chk_val("control after reset", 8'h00, rd);
      end
      $display("Test mid-pulse reset done");
      end_of_test;
   end

endmodule
